// >>> src/dbocs_map.svh
`ifndef DBOCS_MAP_SVH
`define DBOCS_MAP_SVH
// Register indices; byte address is four times the index
`define DBOCS_IDX_PERSIST 10'h067
`define DBOCS_IDX_PTR_HI_1 10'h068
`define DBOCS_IDX_PTR_LO_1 10'h06b
`define DBOCS_IDX_MF_1 10'h06e
`define DBOCS_IDX_OW_1 10'h071
`define DBOCS_IDX_OW_2 10'h072
`define DBOCS_IDX_PTR_HI_2 10'h069
`define DBOCS_IDX_PTR_HI_3 10'h06a
`define DBOCS_IDX_PTR_LO_2 10'h06c
`define DBOCS_IDX_PTR_LO_3 10'h06d
`define DBOCS_IDX_MF_2 10'h06f
`define DBOCS_IDX_MF_3 10'h070
`define DBOCS_IDX_CTRL 10'h080
`define DBOCS_IDX_IRQ_STAT 10'h081
`define DBOCS_IDX_IRQ_MASK 10'h082
// Field positions in the persistent status word and the control word
`define DBOCS_POS_OOF 3
`define DBOCS_POS_LOM 0
`define DBOCS_POS_VC4 0
// Reset values
`define DBOCS_RST_BYTE 8'h00
`define DBOCS_RST_FLAGS 6'h00
// Slot enables over the status word
`define DBOCS_SLOTS_VC4 6'h09
`define DBOCS_SLOTS_ALL 6'h3f
// Answers
`define DBOCS_RESP_OKAY 2'h0
`define DBOCS_RESP_DECERR 2'h3
`endif

// >>> src/dbocs_pkg.sv
package dbocs_pkg;
   typedef enum logic [1:0] {
      DBOCS_OH_PTR_HI,
      DBOCS_OH_PTR_LO,
      DBOCS_OH_MF,
      DBOCS_OH_OW
   } dbocs_oh_kind_type;
   typedef struct packed {
      logic valid;
      dbocs_oh_kind_type kind;
      logic [1:0] slot;
      logic [7:0] data;
   } dbocs_drop_type;
   typedef struct packed {
      logic [2:0] oof;
      logic [2:0] lom;
   } dbocs_alarm_type;
endpackage : dbocs_pkg

// >>> src/dbocs_top.sv
// Behaviour
// - Each slot gets a persistent one-second out-of-multiframe indication.
// - Each slot gets a persistent one-second loss-of-multiframe indication.
// - Bit reads 1 for an interval if alarm active and not newly risen before.
// - Bits 5..3 out-of-multiframe slots 3..1, bits 2..0 loss, bits 7..6 zero.
// - In VC-4 mode slot-one status and capture bits serve the VC-4.
// - Dropped H1 byte held per slot in three consecutive locations.
// - Dropped H2 byte held per slot in three locations after H1.
// - Dropped H4 byte held per slot in three locations after H2.
// - Dropped E1 byte for slot one and two held after H4.
// - Each capture location is refreshed once per frame.
// - Register bit 7 carries byte bit 1, bit 0 carries byte bit 8.
`include "dbocs_map.svh"
module dbocs_top
   import dbocs_pkg::*;
#(
   parameter int NUM_SLOTS = 3,
   parameter int ADDR_WIDTH = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire dbocs_drop_type drop_oh,
   input wire dbocs_alarm_type mf_alarm,
   input wire logic one_sec_pin,
   input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);

   localparam int NUM_CAP = 11;

   if (NUM_SLOTS != 3) begin : g_bad_slots
      $error("dbocs_top serves exactly three slots");
   end
   if (ADDR_WIDTH < 12 || ADDR_WIDTH > 32) begin : g_bad_addr
      $error("dbocs_top needs an address width of 12 to 32 bits");
   end

   // One-second pulse resynchronised; the rising edge is taken between the second and third stages
   logic sec_s1_q;
   logic sec_s2_q;
   logic sec_s3_q;
   logic sec_tick;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sec_s1_q <= 1'b0;
         sec_s2_q <= 1'b0;
         sec_s3_q <= 1'b0;
      end else begin
         sec_s1_q <= one_sec_pin;
         sec_s2_q <= sec_s1_q;
         sec_s3_q <= sec_s2_q;
      end
   end

   assign sec_tick = sec_s2_q & ~sec_s3_q;

   // Control: VC-4 mode
   logic vc4_mode_q;
   logic [5:0] slot_en;

   // In VC-4 mode slots two and three carry no separate path, so hold them at zero
   always_comb begin
      if (vc4_mode_q) begin
         slot_en = `DBOCS_SLOTS_VC4;
      end else begin
         slot_en = `DBOCS_SLOTS_ALL;
      end
   end

   // Persistent one-second indications
   logic [5:0] alarm_now;
   logic [5:0] alarm_prev_q;
   logic [5:0] rose_q;
   logic [5:0] rise;
   logic [5:0] persist_q;
   logic [5:0] persist_d;

   assign alarm_now = {mf_alarm.oof, mf_alarm.lom} & slot_en;
   assign rise = alarm_now & ~alarm_prev_q;
   // A rise on the tick cycle counts against the interval that is ending
   assign persist_d = alarm_now & ~(rose_q | rise);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alarm_prev_q <= `DBOCS_RST_FLAGS;
         rose_q <= `DBOCS_RST_FLAGS;
      end else begin
         alarm_prev_q <= alarm_now;
         if (sec_tick) begin
            rose_q <= `DBOCS_RST_FLAGS;
         end else begin
            rose_q <= rose_q | rise;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         persist_q <= `DBOCS_RST_FLAGS;
      end else if (sec_tick) begin
         persist_q <= persist_d;
      end else begin
         persist_q <= persist_q & slot_en;
      end
   end

   // Overhead byte capture: location = kind * 3 + slot
   logic [7:0] cap_q [NUM_CAP];

   for (genvar i = 0; i < NUM_CAP; i++) begin : g_cap
      localparam logic [1:0] KIND = 2'(i / 3);
      localparam logic [1:0] SLOT = 2'(i % 3);
      logic hit;
      assign hit = drop_oh.valid && drop_oh.kind == dbocs_oh_kind_type'(KIND)
                   && drop_oh.slot == SLOT && slot_en[SLOT];
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            cap_q[i] <= `DBOCS_RST_BYTE;
         end else if (hit) begin
            // Bus bit 7 is the first byte bit on the drop bus
            cap_q[i] <= drop_oh.data;
         end
      end
   end

   // AXI4-Lite write path
   logic aw_got_q;
   logic w_got_q;
   logic aw_got_d;
   logic w_got_d;
   logic [9:0] wr_idx_q;
   logic [31:0] wr_data_q;
   logic [3:0] wr_strb_q;
   logic do_write;
   logic wr_mapped;
   logic [5:0] irq_mask_q;
   logic aw_in_range;
   logic wr_in_range_q;

   assign do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
   // Byte-lane and upper address bits must be zero for an OKAY answer; control and mask writes still land when they are not
   assign aw_in_range = s_axi_awaddr[1:0] == 2'b00 && (s_axi_awaddr >> 12) == '0;

   always_comb begin
      aw_got_d = aw_got_q;
      w_got_d = w_got_q;
      if (do_write) begin
         aw_got_d = 1'b0;
         w_got_d = 1'b0;
      end
      if (s_axi_awvalid && s_axi_awready) begin
         aw_got_d = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_got_d = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         wr_idx_q <= 10'h000;
         wr_data_q <= 32'h0000_0000;
         wr_strb_q <= 4'h0;
         wr_in_range_q <= 1'b0;
      end else begin
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         s_axi_awready <= ~aw_got_d;
         s_axi_wready <= ~w_got_d;
         if (s_axi_awvalid && s_axi_awready) begin
            wr_idx_q <= s_axi_awaddr[11:2];
            wr_in_range_q <= aw_in_range;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_data_q <= s_axi_wdata;
            wr_strb_q <= s_axi_wstrb;
         end
      end
   end

   always_comb begin
      case (wr_idx_q)
         `DBOCS_IDX_PERSIST,
         `DBOCS_IDX_PTR_HI_1,
         `DBOCS_IDX_PTR_HI_2,
         `DBOCS_IDX_PTR_HI_3,
         `DBOCS_IDX_PTR_LO_1,
         `DBOCS_IDX_PTR_LO_2,
         `DBOCS_IDX_PTR_LO_3,
         `DBOCS_IDX_MF_1,
         `DBOCS_IDX_MF_2,
         `DBOCS_IDX_MF_3,
         `DBOCS_IDX_OW_1,
         `DBOCS_IDX_OW_2,
         `DBOCS_IDX_CTRL,
         `DBOCS_IDX_IRQ_STAT,
         `DBOCS_IDX_IRQ_MASK: begin
            wr_mapped = wr_in_range_q;
         end
         default: begin
            wr_mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DBOCS_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? `DBOCS_RESP_OKAY : `DBOCS_RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vc4_mode_q <= 1'b0;
         irq_mask_q <= `DBOCS_RST_FLAGS;
      end else if (do_write && wr_strb_q[0]) begin
         if (wr_idx_q == `DBOCS_IDX_CTRL) begin
            vc4_mode_q <= wr_data_q[`DBOCS_POS_VC4];
         end
         if (wr_idx_q == `DBOCS_IDX_IRQ_MASK) begin
            irq_mask_q <= wr_data_q[5:0];
         end
      end
   end

   // AXI4-Lite read path
   logic ar_take;
   logic rvalid_d;
   logic [9:0] rd_idx;
   logic [7:0] rd_byte;
   logic rd_ok;
   logic [5:0] irq_stat_q;
   logic irq_stat_read;
   logic rd_in_range;

   assign ar_take = s_axi_arvalid & s_axi_arready;
   assign rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
   assign rd_idx = s_axi_araddr[11:2];
   // Same address screening as the write side
   assign rd_in_range = s_axi_araddr[1:0] == 2'b00 && (s_axi_araddr >> 12) == '0;
   assign irq_stat_read = ar_take && rd_in_range && rd_idx == `DBOCS_IDX_IRQ_STAT;

   always_comb begin
      rd_byte = `DBOCS_RST_BYTE;
      rd_ok = rd_in_range;
      case (rd_idx)
         `DBOCS_IDX_PERSIST: begin
            rd_byte = {2'b00, persist_q};
         end
         `DBOCS_IDX_PTR_HI_1: begin
            rd_byte = cap_q[0];
         end
         `DBOCS_IDX_PTR_HI_2: begin
            rd_byte = cap_q[1];
         end
         `DBOCS_IDX_PTR_HI_3: begin
            rd_byte = cap_q[2];
         end
         `DBOCS_IDX_PTR_LO_1: begin
            rd_byte = cap_q[3];
         end
         `DBOCS_IDX_PTR_LO_2: begin
            rd_byte = cap_q[4];
         end
         `DBOCS_IDX_PTR_LO_3: begin
            rd_byte = cap_q[5];
         end
         `DBOCS_IDX_MF_1: begin
            rd_byte = cap_q[6];
         end
         `DBOCS_IDX_MF_2: begin
            rd_byte = cap_q[7];
         end
         `DBOCS_IDX_MF_3: begin
            rd_byte = cap_q[8];
         end
         `DBOCS_IDX_OW_1: begin
            rd_byte = cap_q[9];
         end
         `DBOCS_IDX_OW_2: begin
            rd_byte = cap_q[10];
         end
         `DBOCS_IDX_CTRL: begin
            rd_byte = {7'h00, vc4_mode_q};
         end
         `DBOCS_IDX_IRQ_STAT: begin
            rd_byte = {2'b00, irq_stat_q};
         end
         `DBOCS_IDX_IRQ_MASK: begin
            rd_byte = {2'b00, irq_mask_q};
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
      // A refused address reads as zero whatever its index matched
      if (!rd_ok) begin
         rd_byte = `DBOCS_RST_BYTE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `DBOCS_RESP_OKAY;
      end else begin
         s_axi_arready <= ~rvalid_d;
         s_axi_rvalid <= rvalid_d;
         if (ar_take) begin
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_ok ? `DBOCS_RESP_OKAY : `DBOCS_RESP_DECERR;
         end
      end
   end

   // Interrupt: a persistent bit turning on at the tick is the event
   logic [5:0] irq_event;

   always_comb begin
      if (sec_tick) begin
         irq_event = persist_d & ~persist_q;
      end else begin
         irq_event = `DBOCS_RST_FLAGS;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= `DBOCS_RST_FLAGS;
      end else begin
         // Set wins over the clear-on-read so no event is lost
         irq_stat_q <= (irq_stat_q & ~{6{irq_stat_read}}) | irq_event;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

endmodule : dbocs_top

// >>> tb/dbocs_sva.sv
module dbocs_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rans: assert property (p_rans) else $error("read answer late");
   property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid; endproperty
   a_bans: assert property (p_bans) else $error("write answer late");
   property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_rblk: assert property (p_rblk) else $error("address taken early");
   property p_hi0; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
   a_hi0: assert property (p_hi0) else $error("upper data bits set");
   property p_dec0; s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h00000000;
   endproperty
   a_dec0: assert property (p_dec0) else $error("unmapped read data");
   property p_rst; !$past(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq; endproperty
   a_rst: assert property (p_rst) else $error("outputs set after reset");
endmodule : dbocs_sva

// >>> tb/dbocs_framer.sv
module dbocs_framer
   import dbocs_pkg::*;
(
   input wire logic aclk,
   output dbocs_drop_type drop_oh,
   output dbocs_alarm_type mf_alarm
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      drop_oh = '0;
      mf_alarm = '0;
   end
   task automatic send(input logic [1:0] k, input logic [1:0] s, input logic [7:0] d);
      @(posedge aclk);
      drop_oh <= '{1'b1, dbocs_oh_kind_type'(k), s, d};
      @(posedge aclk);
      // Idle bus shows the inverse, so a stale byte never looks valid
      drop_oh <= '{1'b0, dbocs_oh_kind_type'(k), s, ~d};
   endtask : send
   task automatic alarm(input logic [5:0] a);
      @(posedge aclk);
      mf_alarm <= a;
   endtask : alarm
endmodule : dbocs_framer

// >>> tb/test_dbocs_top.sv
module test_dbocs_top
   import dbocs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, one_sec_pin = 0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rp;
   logic [5:0] al = 0, rose = 0, per = 0, stat = 0, msk;
   logic [7:0] d, cap [11];
   dbocs_drop_type drop_oh;
   dbocs_alarm_type mf_alarm;
   int mismatches = 0, checks = 0, cyc = 0;
   dbocs_top DUT (.*);
   dbocs_framer u_fr (.aclk(aclk), .drop_oh(drop_oh), .mf_alarm(mf_alarm));
   initial forever #25 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic give_verdict;
      if (mismatches == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict
   task automatic bus(input bit wr, input logic [9:0] ix, input logic [31:0] wd);
      bit done, ta, tw, rdy;
      done = 0;
      rdy = 0;
      @(posedge aclk);
      s_axi_awaddr <= {ix, 2'b00};
      s_axi_araddr <= {ix, 2'b00};
      s_axi_wdata <= wd;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_arvalid <= !wr;
      while (!done) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
         tw = s_axi_wvalid && s_axi_wready;
         done = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
         rd = s_axi_rdata;
         rp = wr ? s_axi_bresp : s_axi_rresp;
         // A late ready lets the answer be seen standing
         rdy = !done && (rdy || $urandom % 2 == 1);
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 0;
         if (ta) s_axi_arvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
         s_axi_bready <= wr && rdy;
         s_axi_rready <= !wr && rdy;
      end
   endtask : bus
   task automatic rchk(input logic [9:0] ix, input logic [31:0] e, input logic [1:0] er);
      bus(0, ix, 0);
      chk(rd, e);
      chk(32'(rp), 32'(er));
   endtask : rchk
   task automatic pulse;
      @(posedge aclk);
      one_sec_pin <= 1;
      repeat (4) @(posedge aclk);
      one_sec_pin <= 0;
      repeat (4) @(posedge aclk);
      stat = stat | (al & ~rose & ~per);
      per = al & ~rose;
      rose = 0;
   endtask : pulse
   task automatic send_all(input bit vc4);
      for (int k = 0; k < 4; k++) for (int s = 0; s < 3; s++) repeat (2) begin
         d = 8'($urandom);
         u_fr.send(2'(k), 2'(s), d);
         if ((k < 3 || s < 2) && (!vc4 || s == 0)) cap[k * 3 + s] = d;
      end
      for (int j = 0; j < 11; j++) rchk(10'h068 + 10'(j), 32'(cap[j]), 0);
   endtask : send_all
   initial begin
      void'($urandom(68));
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      for (int i = 0; i < 13; i++) rchk(10'h067 + 10'(i), 0, i < 12 ? 2'h0 : 2'h3);
      for (int n = 0; n < 6; n++) begin
         msk = 6'($urandom);
         bus(1, 10'h082, 32'(msk));
         if (n % 2 == 0) begin
            d = 8'($urandom);
            u_fr.alarm(d[5:0]);
            rose = rose | (d[5:0] & ~al);
            al = d[5:0];
         end
         repeat (3) @(posedge aclk);
         pulse();
         rchk(10'h067, 32'(per), 0);
         @(negedge aclk);
         chk(32'(irq), 32'(|(stat & msk)));
         rchk(10'h081, 32'(stat), 0);
         stat = 0;
         repeat (3) @(negedge aclk);
         chk(32'(irq), 0);
      end
      send_all(0);
      bus(1, 10'h068, 32'h000000ff);
      chk(32'(rp), 0);
      rchk(10'h068, 32'(cap[0]), 0);
      bus(1, 10'h073, 32'h000000ff);
      chk(32'(rp), 32'h3);
      bus(1, 10'h080, 32'h00000001);
      send_all(1);
      // In VC-4 mode only the slot-one bits may follow the alarms
      al = al & 6'h09;
      per = per & 6'h09;
      u_fr.alarm(6'h3f);
      rose = rose | (6'h09 & ~al);
      al = 6'h09;
      repeat (3) @(posedge aclk);
      pulse();
      rchk(10'h067, 32'(per), 0);
      give_verdict();
   end
endmodule : test_dbocs_top
bind dbocs_top dbocs_sva u_sva (.*);
